/* File: pkg/pmicw_defines.vh */
// register map, field positions, reset values and timing constants of the interrupt block
`ifndef PMICW_DEFINES_VH
`define PMICW_DEFINES_VH

// ==========================================================
// register offsets (word port behind the serial interface)
`define PMICW_AW 15
`define PMICW_DW 16
`define PMICW_A_EN_LO 15'h0160
`define PMICW_A_EN_HI 15'h0166
`define PMICW_A_ST_LO 15'h0172
`define PMICW_A_ST_HI 15'h0174
`define PMICW_A_CTRL 15'h0178
`define PMICW_A_KICK 15'h017A
`define PMICW_A_LEVEL 15'h017C
`define PMICW_A_BATH_THR 15'h017E
`define PMICW_A_BATL_THR 15'h0180

// ==========================================================
// status and enable bits, low word
`define PMICW_B_SPK_AB 0
`define PMICW_B_SPK 1
`define PMICW_B_BAT_L 2
`define PMICW_B_BAT_H 3
`define PMICW_B_WDT 4
`define PMICW_B_POWER_KEY 5
`define PMICW_B_TEMP_RECOVERED_EVENT 6
`define PMICW_B_OVER_TEMP_EVENT 7
`define PMICW_B_VBATON 8
`define PMICW_B_BVALID 9
`define PMICW_B_CHARGER_PRESENT_EVENT 10
`define PMICW_B_OV 11
// high word
`define PMICW_B_LDO 0
`define PMICW_B_CHGKEY 1
`define PMICW_B_ACCDET 2
`define PMICW_B_AUDIO 3
`define PMICW_B_RTC 4
`define PMICW_B_CORE 5
`define PMICW_B_SYS 6
`define PMICW_B_PA 7
`define PMICW_ST_LO_MASK 16'h0FFF
`define PMICW_ST_HI_MASK 16'h00FF

// ==========================================================
// control register fields
`define PMICW_C_CHG_EN 0
`define PMICW_C_GEAR_LO 1
`define PMICW_C_GEAR_HI 2
`define PMICW_C_LDO_LO 3
`define PMICW_C_LDO_HI 4
`define PMICW_C_BUS_LO 5
`define PMICW_C_BUS_HI 6
`define PMICW_C_PWR_REL 7
`define PMICW_C_CHG_REL 8
`define PMICW_C_WAKE_EN 9
`define PMICW_CTRL_MASK 16'h03FF
`define PMICW_CTRL_RST 16'h0380
`define PMICW_EN_RST 16'h0000
`define PMICW_BATH_RST 15'h7FFF
`define PMICW_BATL_RST 15'h0000
`define PMICW_PIN_IDLE 17'h04000

// ==========================================================
// timing
`define PMICW_CLK_KHZ 40000
`define PMICW_KEY_DEB_MS 50
`define PMICW_OV_DEG_NS 4000
`define PMICW_BUCK_DEB_NS 2000
`define PMICW_DEB_UNIT_US 100
`define PMICW_WDT_BASE_S 4
`define PMICW_NS_PER_MS 1000000

`endif

/* File: verilog/pmicw_debounce.v */
// level debouncer: output follows input once it has held for a programmed count
`timescale 1ns/1ps
`default_nettype none

module pmicw_debounce (
  input wire i_ref_clk, // system clock
  input wire i_rst, // async reset, active high
  input wire i_level, // synchronised raw level
  input wire [31:0] i_limit, // cycles of stability needed, 0 passes next cycle
  output wire o_level // debounced level
);

  reg lvl_q;
  reg [31:0] cnt_q;

  // ==========================================================
  // stability counter
  // any return to the old level restarts the count, so short glitches vanish
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lvl_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (i_level == lvl_q) begin
      cnt_q <= 32'h0;
    end else if (cnt_q + 32'h1 >= i_limit) begin
      lvl_q <= i_level;
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign o_level = lvl_q;

endmodule

`default_nettype wire

/* File: verilog/pmicw_top.v */
// interrupt aggregation and charger watchdog of the power-management chip
`timescale 1ns/1ps
`default_nettype none
`include "pmicw_defines.vh"

module pmicw_top #(
  parameter [31:0] P_KEY_DEB_CYC = `PMICW_KEY_DEB_MS * `PMICW_CLK_KHZ, // 50 ms
  parameter [31:0] P_DEB_UNIT_CYC = `PMICW_DEB_UNIT_US * `PMICW_CLK_KHZ / 1000, // 100 us
  parameter [31:0] P_WDT_BASE_CYC = `PMICW_WDT_BASE_S * `PMICW_CLK_KHZ * 1000 // 4 s
) (
  input wire i_ref_clk, // 40 MHz always-on clock
  input wire i_rst, // async reset, active high
  input wire i_reg_wr, // register write strobe
  input wire i_reg_rd, // register read strobe
  input wire [`PMICW_AW-1:0] i_reg_addr, // register offset
  input wire [`PMICW_DW-1:0] i_reg_wdata, // write data
  output wire [`PMICW_DW-1:0] o_reg_rdata, // read data, valid the cycle after i_reg_rd
  input wire [14:0] i_vbat_code, // battery voltage code from the converter
  input wire i_power_key, // power key pin, high while pressed
  input wire i_charge_key, // charge key pin, high while pressed
  input wire i_temp_hot, // die above 125 C comparator
  input wire i_temp_cool, // die below 110 C comparator
  input wire i_charger_present, // charger detect comparator
  input wire i_charger_ov, // charger over-voltage comparator
  input wire i_bus_valid, // bus-valid detect, high active
  input wire i_battery_absent, // battery not detected, high active
  input wire i_spk_oc, // speaker over-current, high active
  input wire i_spk_ab_oc, // speaker class-ab over-current, high active
  input wire i_pa_buck_oc, // pa buck over-current
  input wire i_sys_buck_oc, // system buck over-current
  input wire i_core_buck_oc, // core buck over-current
  input wire i_regulator_oc, // or of all ldo over-current flags
  input wire i_rtc_irq_n, // calendar interrupt and alarm, active low
  input wire i_audio_irq, // audio status interrupt, high active
  input wire i_accdet_irq, // accessory detect interrupt, high active
  output wire o_int, // interrupt to host, active high
  output wire o_charge_enable, // charging permitted
  output wire o_host_wake // wake request to host
);

  localparam [31:0] L_OV_CYC =
    (`PMICW_OV_DEG_NS * `PMICW_CLK_KHZ + `PMICW_NS_PER_MS - 1) / `PMICW_NS_PER_MS;
  localparam [31:0] L_BUCK_CYC =
    (`PMICW_BUCK_DEB_NS * `PMICW_CLK_KHZ + `PMICW_NS_PER_MS - 1) / `PMICW_NS_PER_MS;
  localparam NPIN = 17;
  localparam NDB = 12;
  // debouncer slots
  localparam D_PWR = 0;
  localparam D_CHGK = 1;
  localparam D_HOT = 2;
  localparam D_COOL = 3;
  localparam D_CHR = 4;
  localparam D_OV = 5;
  localparam D_BVAL = 6;
  localparam D_VBAT = 7;
  localparam D_PA = 8;
  localparam D_SYS = 9;
  localparam D_CORE = 10;
  localparam D_LDO = 11;

  // ==========================================================
  // helpers
  // selectable debounce length: unit scaled by 1/2/4/8, or 0/1/2/4 when zero_first
  function [31:0] deb_len;
    input [31:0] unit;
    input [1:0] sel;
    input zero_first;
    begin
      if (zero_first && sel == 2'h0) begin
        deb_len = 32'h0;
      end else if (zero_first) begin
        deb_len = unit << (sel - 2'h1);
      end else begin
        deb_len = unit << sel;
      end
    end
  endfunction

  // write-one-to-clear with set taking priority
  function [15:0] w1c;
    input [15:0] cur;
    input [15:0] set;
    input clr_en;
    input [15:0] clr;
    begin
      w1c = (cur & ~(clr_en ? clr : 16'h0000)) | set;
    end
  endfunction

  // ==========================================================
  // registers
  reg [15:0] en_lo_q;
  reg [15:0] en_hi_q;
  reg [15:0] st_lo_q;
  reg [15:0] st_hi_q;
  reg [15:0] ctrl_q;
  reg [14:0] bath_thr_q;
  reg [14:0] batl_thr_q;
  reg [15:0] rdata_q;
  reg [NPIN-1:0] meta_q;
  reg [NPIN-1:0] sync_q;
  reg [NDB-1:0] deb_prev_q;
  reg [31:0] wdt_cnt_q;
  reg wdt_exp_q;

  wire [NPIN-1:0] pins_raw;
  wire [NDB-1:0] deb_in;
  wire [NDB-1:0] deb;
  wire [NDB-1:0] rise;
  wire [NDB-1:0] fall;
  wire [31:0] ldo_len;
  wire [31:0] bus_len;
  wire [31:0] wdt_lim;
  wire wr_en_lo;
  wire wr_en_hi;
  wire wr_st_lo;
  wire wr_st_hi;
  wire wr_ctrl;
  wire wr_kick;
  wire wr_bath;
  wire wr_batl;
  wire chg_en;
  wire [15:0] ev_lo;
  wire [15:0] ev_hi;
  wire [15:0] level_word;
  reg [15:0] rd_mux;

  // ==========================================================
  // pin synchronisers
  assign pins_raw = {i_accdet_irq, i_audio_irq, i_rtc_irq_n, i_spk_oc,
                     i_spk_ab_oc, i_regulator_oc, i_core_buck_oc, i_sys_buck_oc,
                     i_pa_buck_oc, i_battery_absent, i_bus_valid, i_charger_ov,
                     i_charger_present, i_temp_cool, i_temp_hot, i_charge_key,
                     i_power_key};

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      // calendar pin idles high in both stages, else a false alarm follows reset
      meta_q <= `PMICW_PIN_IDLE;
      sync_q <= `PMICW_PIN_IDLE;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // debouncers
  // the first twelve synced pins feed the debouncers in slot order
  assign deb_in = sync_q[NDB-1:0];
  assign ldo_len = deb_len(P_DEB_UNIT_CYC, ctrl_q[`PMICW_C_LDO_HI:`PMICW_C_LDO_LO], 1'b0);
  assign bus_len = deb_len(P_DEB_UNIT_CYC, ctrl_q[`PMICW_C_BUS_HI:`PMICW_C_BUS_LO], 1'b1);

  genvar gi;
  generate
    for (gi = 0; gi < NDB; gi = gi + 1) begin : g_deb
      wire [31:0] lim;
      assign lim = (gi == D_OV) ? L_OV_CYC :
                   (gi == D_BVAL || gi == D_VBAT) ? bus_len :
                   (gi == D_PA || gi == D_SYS || gi == D_CORE) ? L_BUCK_CYC :
                   (gi == D_LDO) ? ldo_len : P_KEY_DEB_CYC;
      pmicw_debounce u_deb (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_level(deb_in[gi]),
        .i_limit(lim),
        .o_level(deb[gi])
      );
    end
  endgenerate

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      deb_prev_q <= {NDB{1'b0}};
    end else begin
      deb_prev_q <= deb;
    end
  end

  assign rise = deb & ~deb_prev_q;
  assign fall = ~deb & deb_prev_q;

  // ==========================================================
  // register decode
  assign wr_en_lo = i_reg_wr && i_reg_addr == `PMICW_A_EN_LO;
  assign wr_en_hi = i_reg_wr && i_reg_addr == `PMICW_A_EN_HI;
  assign wr_st_lo = i_reg_wr && i_reg_addr == `PMICW_A_ST_LO;
  assign wr_st_hi = i_reg_wr && i_reg_addr == `PMICW_A_ST_HI;
  assign wr_ctrl = i_reg_wr && i_reg_addr == `PMICW_A_CTRL;
  assign wr_kick = i_reg_wr && i_reg_addr == `PMICW_A_KICK;
  assign wr_bath = i_reg_wr && i_reg_addr == `PMICW_A_BATH_THR;
  assign wr_batl = i_reg_wr && i_reg_addr == `PMICW_A_BATL_THR;
  assign chg_en = ctrl_q[`PMICW_C_CHG_EN];

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      en_lo_q <= `PMICW_EN_RST;
      en_hi_q <= `PMICW_EN_RST;
      ctrl_q <= `PMICW_CTRL_RST;
      bath_thr_q <= `PMICW_BATH_RST;
      batl_thr_q <= `PMICW_BATL_RST;
    end else begin
      if (wr_en_lo) begin
        en_lo_q <= i_reg_wdata;
      end
      if (wr_en_hi) begin
        en_hi_q <= i_reg_wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= i_reg_wdata & `PMICW_CTRL_MASK;
      end
      if (wr_bath) begin
        bath_thr_q <= i_reg_wdata[14:0];
      end
      if (wr_batl) begin
        batl_thr_q <= i_reg_wdata[14:0];
      end
    end
  end

  // ==========================================================
  // charger watchdog
  assign wdt_lim = P_WDT_BASE_CYC << ctrl_q[`PMICW_C_GEAR_HI:`PMICW_C_GEAR_LO];

  // a kick also lifts a past expiry, so software can resume charging
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_cnt_q <= 32'h0;
      wdt_exp_q <= 1'b0;
    end else if (!chg_en || wr_kick) begin
      wdt_cnt_q <= 32'h0;
      wdt_exp_q <= 1'b0;
    end else if (!wdt_exp_q) begin
      if (wdt_cnt_q + 32'h1 >= wdt_lim) begin
        wdt_exp_q <= 1'b1;
      end else begin
        wdt_cnt_q <= wdt_cnt_q + 32'h1;
      end
    end
  end

  assign o_charge_enable = deb[D_CHR] & chg_en & ~wdt_exp_q;

  // ==========================================================
  // event sources
  assign ev_lo[`PMICW_B_SPK_AB] = sync_q[12];
  assign ev_lo[`PMICW_B_SPK] = sync_q[13];
  assign ev_lo[`PMICW_B_BAT_L] = i_vbat_code < batl_thr_q;
  assign ev_lo[`PMICW_B_BAT_H] = i_vbat_code > bath_thr_q;
  assign ev_lo[`PMICW_B_WDT] = wdt_exp_q;
  assign ev_lo[`PMICW_B_POWER_KEY] = rise[D_PWR] |
                                  (fall[D_PWR] & ctrl_q[`PMICW_C_PWR_REL]);
  assign ev_lo[`PMICW_B_TEMP_RECOVERED_EVENT] = rise[D_COOL];
  assign ev_lo[`PMICW_B_OVER_TEMP_EVENT] = rise[D_HOT];
  assign ev_lo[`PMICW_B_VBATON] = deb[D_VBAT];
  assign ev_lo[`PMICW_B_BVALID] = deb[D_BVAL];
  assign ev_lo[`PMICW_B_CHARGER_PRESENT_EVENT] = rise[D_CHR] | fall[D_CHR];
  assign ev_lo[`PMICW_B_OV] = rise[D_OV];
  assign ev_lo[15:12] = 4'h0;

  assign ev_hi[`PMICW_B_LDO] = deb[D_LDO];
  assign ev_hi[`PMICW_B_CHGKEY] = rise[D_CHGK] |
                                  (fall[D_CHGK] & ctrl_q[`PMICW_C_CHG_REL]);
  assign ev_hi[`PMICW_B_ACCDET] = sync_q[16];
  assign ev_hi[`PMICW_B_AUDIO] = sync_q[15];
  assign ev_hi[`PMICW_B_RTC] = ~sync_q[14];
  assign ev_hi[`PMICW_B_CORE] = deb[D_CORE];
  assign ev_hi[`PMICW_B_SYS] = deb[D_SYS];
  assign ev_hi[`PMICW_B_PA] = deb[D_PA];
  assign ev_hi[15:8] = 8'h00;

  // ==========================================================
  // sticky status
  // a source only latches while its enable is set; level sources re-set
  // every cycle they stay active, so a clear cannot hide a live condition
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_lo_q <= 16'h0000;
      st_hi_q <= 16'h0000;
    end else begin
      st_lo_q <= w1c(st_lo_q, ev_lo & en_lo_q & `PMICW_ST_LO_MASK,
                     wr_st_lo, i_reg_wdata);
      st_hi_q <= w1c(st_hi_q, ev_hi & en_hi_q & `PMICW_ST_HI_MASK,
                     wr_st_hi, i_reg_wdata);
    end
  end

  assign o_int = |(st_lo_q & en_lo_q) | |(st_hi_q & en_hi_q);

  // alarm level wakes the host from the synchronised pin, two cycles late, even with status masked
  assign o_host_wake = ~sync_q[14] & ctrl_q[`PMICW_C_WAKE_EN];

  // ==========================================================
  // read path
  assign level_word = {11'h000, wdt_exp_q, o_charge_enable, deb[D_CHR],
                       deb[D_CHGK], deb[D_PWR]};

  always @* begin
    case (i_reg_addr)
      `PMICW_A_EN_LO: rd_mux = en_lo_q;
      `PMICW_A_EN_HI: rd_mux = en_hi_q;
      `PMICW_A_ST_LO: rd_mux = st_lo_q;
      `PMICW_A_ST_HI: rd_mux = st_hi_q;
      `PMICW_A_CTRL: rd_mux = ctrl_q;
      `PMICW_A_LEVEL: rd_mux = level_word;
      `PMICW_A_BATH_THR: rd_mux = {1'b0, bath_thr_q};
      `PMICW_A_BATL_THR: rd_mux = {1'b0, batl_thr_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 16'h0000;
    end else if (i_reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule

`default_nettype wire

/* File: test/pmicw_monitor.sv */
// assertion checker for the interrupt and charger watchdog block
`timescale 1ns/1ps
`default_nettype none
module pmicw_monitor #(
  parameter [31:0] P_WDT_BASE_CYC = 50,
  parameter [31:0] P_KEY_DEB_CYC = 8
) (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst, // async reset
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [14:0] i_reg_addr, // offset
  input wire logic [15:0] o_reg_rdata, // read data
  input wire logic i_charger_present, // charger comparator
  input wire logic i_rtc_irq_n, // calendar irq, low active
  input wire logic o_int, // host interrupt
  input wire logic o_charge_enable, // charge permit
  input wire logic o_host_wake // wake output
);
  // ======================================
  // helper: charge time without any host write
  // slowest gear plus slack for the arming write
  localparam [31:0] WDT_MAX = (P_WDT_BASE_CYC << 3) + 32'h4;
  logic [31:0] chg_cyc_q;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      chg_cyc_q <= 32'h0;
    else if (i_reg_wr || !o_charge_enable)
      chg_cyc_q <= 32'h0;
    else
      chg_cyc_q <= chg_cyc_q + 32'h1;
  end
  // charger gone long enough for sync and debounce to have dropped it
  localparam [31:0] ABSENT_MAX = P_KEY_DEB_CYC + 32'h4;
  logic [31:0] absent_cyc_q;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      absent_cyc_q <= 32'h0;
    else if (i_charger_present)
      absent_cyc_q <= 32'h0;
    else if (absent_cyc_q <= ABSENT_MAX)
      absent_cyc_q <= absent_cyc_q + 32'h1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ======================================
  // properties
  a_reset_quiet: assert property ($past(i_rst) |-> !o_int && !o_charge_enable
    && o_reg_rdata == 16'h0000) else $error("outputs not idle after reset");
  a_int_fall_write: assert property ($fell(o_int) |-> $past(i_reg_wr))
    else $error("interrupt dropped without a host write");
  a_rdata_hold: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr[0] |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_st_lo_top: assert property (i_reg_rd && i_reg_addr == 15'h0172
    |=> o_reg_rdata[15:12] == 4'h0) else $error("status low spare bits set");
  a_st_hi_top: assert property (i_reg_rd && i_reg_addr == 15'h0174
    |=> o_reg_rdata[15:8] == 8'h00) else $error("status high spare bits set");
  a_wake_source: assert property (o_host_wake |-> !$past(i_rtc_irq_n, 2))
    else $error("wake without calendar alarm");
  a_charge_needs_present: assert property (absent_cyc_q > ABSENT_MAX
    |-> !o_charge_enable) else $error("charging without charger");
  a_wdt_bound: assert property (chg_cyc_q <= WDT_MAX)
    else $error("watchdog let charging run past its period");
endmodule

bind pmicw_top pmicw_monitor #(.P_WDT_BASE_CYC(P_WDT_BASE_CYC),
  .P_KEY_DEB_CYC(P_KEY_DEB_CYC)) i_pmicw_monitor (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .i_charger_present(i_charger_present),
  .i_rtc_irq_n(i_rtc_irq_n), .o_int(o_int), .o_charge_enable(o_charge_enable),
  .o_host_wake(o_host_wake));
`default_nettype wire

/* File: test/pmicw_host.sv */
// register host model standing in for the baseband side
`timescale 1ns/1ps
`default_nettype none
module pmicw_host (
  input wire logic i_ref_clk, // clock
  input wire logic [15:0] i_rdata, // read data
  output var logic o_wr, // write strobe
  output var logic o_rd, // read strobe
  output var logic [14:0] o_addr, // offset
  output var logic [15:0] o_wdata // write data
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 15'h0000;
    o_wdata = 16'h0000;
  end
  // one-cycle strobe; idle bus shows inverted values, never the last ones
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(negedge i_ref_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [14:0] a, output logic [15:0] d);
    @(negedge i_ref_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

/* File: test/pmic_interrupt_and_charge_watchdog_tb.sv */
// self-checking bench for the interrupt and charger watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "pmicw_defines.vh"
module pmic_interrupt_and_charge_watchdog_tb;
  localparam int UNIT = 4;
  localparam int WDT = 50;
  logic i_ref_clk, i_rst, wr, rd, o_int, chg, wake;
  logic [14:0] addr, vbat, th, tl;
  logic [15:0] wdata, rdata, d;
  logic [16:0] src;
  int num_errors, checks_done, cyc, seed;
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  pmicw_top #(.P_KEY_DEB_CYC(8), .P_DEB_UNIT_CYC(UNIT), .P_WDT_BASE_CYC(WDT)) i_pmicw_top (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_vbat_code(vbat), .i_power_key(src[0]),
    .i_charge_key(src[1]), .i_temp_hot(src[2]), .i_temp_cool(src[3]),
    .i_charger_present(src[4]), .i_charger_ov(src[5]), .i_bus_valid(src[6]),
    .i_battery_absent(src[7]), .i_spk_oc(src[8]), .i_spk_ab_oc(src[9]),
    .i_pa_buck_oc(src[10]), .i_sys_buck_oc(src[11]), .i_core_buck_oc(src[12]),
    .i_regulator_oc(src[13]), .i_rtc_irq_n(~src[14]), .i_audio_irq(src[15]),
    .i_accdet_irq(src[16]), .o_int(o_int), .o_charge_enable(chg), .o_host_wake(wake));
  pmicw_host i_pmicw_host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  // ======================================
  // checking
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [14:0] a, input logic [15:0] m, input logic [15:0] e);
    i_pmicw_host.rd(a, d);
    chk($sformatf("reg %h", a), e, d & m);
  endtask
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] bat_exp(input logic [14:0] v, hi, lo);
    bat_exp = {12'h000, v > hi, v < lo, 2'b00};
  endfunction
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report;
    end
  end
  // ======================================
  // one source: set, masked, cleared by writing one, second edge where it has one
  task automatic run_src(input int idx, input bit hi, input int b, input bit aft, input int wt);
    logic [14:0] st, en;
    logic [15:0] m;
    st = hi ? `PMICW_A_ST_HI : `PMICW_A_ST_LO;
    en = hi ? `PMICW_A_EN_HI : `PMICW_A_EN_LO;
    m = 16'h0001 << b;
    src[idx] = 1'b1;
    repeat (wt) @(negedge i_ref_clk);
    rd_chk(st, 16'hFFFF, m);
    chk("int", 16'h0001, {15'h0, o_int});
    i_pmicw_host.wr(en, 16'h0000);
    chk("int masked", 16'h0000, {15'h0, o_int});
    i_pmicw_host.wr(en, 16'hFFFF);
    if (idx < 2)
      rd_chk(`PMICW_A_LEVEL, 16'h0003, 16'h0001 << idx);
    i_pmicw_host.wr(st, m);
    src[idx] = 1'b0;
    repeat (wt) @(negedge i_ref_clk);
    i_pmicw_host.wr(st, 16'h0000);
    rd_chk(st, 16'hFFFF, aft ? m : 16'h0000);
    i_pmicw_host.wr(st, m);
    rd_chk(st, 16'hFFFF, 16'h0000);
    chk("int idle", 16'h0000, {15'h0, o_int});
  endtask
  // a pulse two cycles short of the filter must not pass, a long one must
  task automatic deb_sel(input int idx, input logic [14:0] st, input int b, sh, s, len);
    i_pmicw_host.wr(`PMICW_A_CTRL, 16'h0380 | 16'(s << sh));
    src[idx] = 1'b1;
    repeat (len - 2) @(negedge i_ref_clk);
    src[idx] = 1'b0;
    repeat (len + 6) @(negedge i_ref_clk);
    rd_chk(st, 16'h0001 << b, 16'h0000);
    src[idx] = 1'b1;
    repeat (len + 6) @(negedge i_ref_clk);
    src[idx] = 1'b0;
    repeat (len + 6) @(negedge i_ref_clk);
    rd_chk(st, 16'h0001 << b, 16'h0001 << b);
    i_pmicw_host.wr(st, 16'hFFFF);
  endtask
  // ======================================
  // main sequence
  initial begin
    seed = 32'h2927;
    src = 17'h00000;
    vbat = 15'h4000;
    i_rst = 1'b1;
    repeat (2) @(negedge i_ref_clk);
    i_rst = 1'b0;
    rd_chk(`PMICW_A_EN_LO, 16'hFFFF, 16'h0000);
    rd_chk(`PMICW_A_EN_HI, 16'hFFFF, 16'h0000);
    rd_chk(`PMICW_A_ST_LO, 16'hFFFF, 16'h0000);
    rd_chk(`PMICW_A_ST_HI, 16'hFFFF, 16'h0000);
    rd_chk(`PMICW_A_CTRL, 16'hFFFF, 16'h0380);
    rd_chk(`PMICW_A_BATH_THR, 16'hFFFF, 16'h7FFF);
    rd_chk(`PMICW_A_KICK, 16'hFFFF, 16'h0000);
    i_pmicw_host.wr(15'h0101, 16'hFFFF);
    rd_chk(15'h0101, 16'hFFFF, 16'h0000);
    i_pmicw_host.wr(`PMICW_A_LEVEL, 16'hFFFF);
    rd_chk(`PMICW_A_LEVEL, 16'hFFFF, 16'h0000);
    i_pmicw_host.wr(`PMICW_A_EN_LO, 16'hFFFF);
    i_pmicw_host.wr(`PMICW_A_EN_HI, 16'hFFFF);
    run_src(0, 0, 5, 1, 20);
    run_src(1, 1, 1, 1, 20);
    run_src(2, 0, 7, 0, 20);
    run_src(3, 0, 6, 0, 20);
    run_src(4, 0, 10, 1, 20);
    run_src(5, 0, 11, 0, 170);
    run_src(6, 0, 9, 1, 8);
    run_src(7, 0, 8, 1, 8);
    run_src(8, 0, 1, 1, 6);
    run_src(9, 0, 0, 1, 6);
    run_src(10, 1, 7, 1, 90);
    run_src(11, 1, 6, 1, 90);
    run_src(12, 1, 5, 1, 90);
    run_src(13, 1, 0, 1, 12);
    run_src(14, 1, 4, 1, 6);
    run_src(15, 1, 3, 1, 6);
    run_src(16, 1, 2, 1, 6);
    for (int s = 0; s < 4; s++)
      deb_sel(13, `PMICW_A_ST_HI, 0, 3, s, UNIT << s);
    for (int s = 1; s < 4; s++)
      deb_sel(6, `PMICW_A_ST_LO, 9, 5, s, UNIT << (s - 1));
    for (int k = 0; k < 8; k++) begin
      th = 15'($random(seed));
      tl = 15'($random(seed));
      i_pmicw_host.wr(`PMICW_A_BATH_THR, {1'b0, th});
      i_pmicw_host.wr(`PMICW_A_BATL_THR, {1'b0, tl});
      vbat = (k == 0) ? th : (k == 1) ? tl : 15'($random(seed));
      repeat (2) @(negedge i_ref_clk);
      i_pmicw_host.wr(`PMICW_A_ST_LO, 16'h000C);
      rd_chk(`PMICW_A_ST_LO, 16'h000C, bat_exp(vbat, th, tl));
    end
    i_pmicw_host.wr(`PMICW_A_CTRL, 16'h0380);
    src[14] = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    chk("wake", 16'h0001, {15'h0, wake});
    i_pmicw_host.wr(`PMICW_A_CTRL, 16'h0180);
    chk("wake masked", 16'h0000, {15'h0, wake});
    src[14] = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    chk("wake", 16'h0000, {15'h0, wake});
    src[4] = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    for (int g = 0; g < 4; g++) begin
      i_pmicw_host.wr(`PMICW_A_CTRL, 16'h0381 | 16'(g << 1));
      i_pmicw_host.wr(`PMICW_A_ST_LO, 16'h0010);
      repeat ((WDT << g) - 10) @(negedge i_ref_clk);
      i_pmicw_host.wr(`PMICW_A_KICK, 16'h0000);
      repeat ((WDT << g) - 10) @(negedge i_ref_clk);
      chk("charge", 16'h0001, {15'h0, chg});
      rd_chk(`PMICW_A_ST_LO, 16'h0010, 16'h0000);
      repeat (20) @(negedge i_ref_clk);
      chk("charge", 16'h0000, {15'h0, chg});
      rd_chk(`PMICW_A_ST_LO, 16'h0010, 16'h0010);
      rd_chk(`PMICW_A_LEVEL, 16'h001C, 16'h0014);
      i_pmicw_host.wr(`PMICW_A_KICK, 16'h0000);
      chk("charge", 16'h0001, {15'h0, chg});
    end
    src[4] = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    chk("charge", 16'h0000, {15'h0, chg});
    final_report;
  end
endmodule
`default_nettype wire
